/* verilog/lcpf_pkg.sv */
// Package: constants and types for the LCD pin function control block
package lcpf_pkg;

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	localparam int          LCPF_ADDR_W     = 8;
	localparam int          LCPF_DATA_W     = 8;
	localparam logic [7:0]  LCPF_CTRL_OFF   = 8'hc0;
	localparam logic [7:0]  LCPF_CTRL_RESET = 8'h00;
	localparam logic [7:0]  LCPF_READ_IDLE  = 8'h00;

	// ----------------------------------------------------------------
	// Field positions inside the control register
	// ----------------------------------------------------------------
	localparam int          LCPF_DUTY_LSB   = 6;
	localparam int          LCPF_DUP_BIT    = 5;
	localparam int          LCPF_EXP_BIT    = 4;
	localparam int          LCPF_GROUP_LSB  = 0;

	// ----------------------------------------------------------------
	// Pin geometry
	// ----------------------------------------------------------------
	localparam int          LCPF_SEG_PINS   = 40;
	localparam int          LCPF_GROUP_W    = 8;
	localparam int          LCPF_GROUPS     = 5;
	localparam int          LCPF_EXP_LSB    = 36;
	localparam int          LCPF_EXP_N      = 4;
	localparam int          LCPF_COMS       = 4;
	localparam logic [3:0]  LCPF_ALL_PORT   = 4'h0;

	// Common enable patterns
	localparam logic [3:0]  LCPF_EN_ONE     = 4'h1;
	localparam logic [3:0]  LCPF_EN_TWO     = 4'h3;
	localparam logic [3:0]  LCPF_EN_THREE   = 4'h7;
	localparam logic [3:0]  LCPF_EN_ALL     = 4'hf;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		LCPF_DUTY_STATIC  = 2'h0,
		LCPF_DUTY_HALF    = 2'h1,
		LCPF_DUTY_THIRD   = 2'h2,
		LCPF_DUTY_QUARTER = 2'h3
	} lcpf_duty_e;

	typedef struct packed {
		lcpf_duty_e  duty;        // duty_select_high, duty_select_low
		logic        com_dup;     // common_duplicate_select
		logic        exp_sel;     // expansion_signal_select
		logic [3:0]  group;       // segment_group_bit3..0
	} lcpf_ctrl_s;

	// Order matches the top pins, highest pin first
	typedef struct packed {
		logic        latch_clk;   // expansion_latch_clock
		logic        shift_clk;   // expansion_shift_clock
		logic        ser_data;
		logic        alternation;
	} lcpf_exp_s;

endpackage

/* verilog/lcpf_com_map.sv */
// Common driver mapping: duty and duplication onto four commons
`timescale 1ns/100ps
`default_nettype none

module lcpf_com_map
	import lcpf_pkg::*;
(
	input  wire logic        clk,      // System clock
	input  wire logic        rst_n,    // Async reset, active low
	input  wire lcpf_ctrl_s  ctrl,     // Current control register
	input  wire logic [3:0]  phase,    // Common slot waveforms
	output var  logic [3:0]  com_o,    // Common pin levels
	output var  logic [3:0]  com_en    // Common pin drive enables
);

	logic [3:0] next_com_o;
	logic [3:0] next_com_en;
	logic       live;
	logic       next_live;

	// ----------------------------------------------------------------
	// Mapping
	// ----------------------------------------------------------------
	always_comb begin
		next_live   = 1'b1;
		next_com_o  = {3'h0, phase[0]};
		next_com_en = LCPF_EN_ONE;
		case (ctrl.duty)
			LCPF_DUTY_STATIC: begin
				if (ctrl.com_dup) begin
					next_com_o  = {4{phase[0]}};
					next_com_en = LCPF_EN_ALL;
				end else begin
					next_com_o  = {3'h0, phase[0]};
					next_com_en = LCPF_EN_ONE;
				end
			end
			LCPF_DUTY_HALF: begin
				if (ctrl.com_dup) begin
					next_com_o  = {phase[1], phase[1], phase[0], phase[0]};
					next_com_en = LCPF_EN_ALL;
				end else begin
					next_com_o  = {2'h0, phase[1:0]};
					next_com_en = LCPF_EN_TWO;
				end
			end
			LCPF_DUTY_THIRD: begin
				// Duplicate bit has no effect here; fourth common stays idle
				next_com_o  = {1'h0, phase[2:0]};
				next_com_en = LCPF_EN_THREE;
			end
			LCPF_DUTY_QUARTER: begin
				next_com_o  = phase;
				next_com_en = LCPF_EN_ALL;
			end
			default: begin
				next_com_o  = {3'h0, phase[0]};
				next_com_en = LCPF_EN_ONE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			com_o  <= 4'h0;
			com_en <= 4'h0;
			live   <= 1'b0;
		end else begin
			com_o  <= next_com_o;
			com_en <= next_com_en;
			live   <= next_live;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	property p_static_one;
		(live && ctrl.duty == LCPF_DUTY_STATIC && !ctrl.com_dup) |=>
			(com_en == 4'h1 && com_o == {3'h0, $past(phase[0])});
	endproperty
	a_static_one: assert property (p_static_one) else $error("static single common wrong");

	property p_static_dup;
		(live && ctrl.duty == LCPF_DUTY_STATIC && ctrl.com_dup) |=>
			(com_en == 4'hf && com_o == {4{$past(phase[0])}});
	endproperty
	a_static_dup: assert property (p_static_dup) else $error("static duplicated commons wrong");

	property p_half_two;
		(live && ctrl.duty == LCPF_DUTY_HALF && !ctrl.com_dup) |=>
			(com_en == 4'h3 && com_o[3:2] == 2'h0 && com_o[1:0] == $past(phase[1:0]));
	endproperty
	a_half_two: assert property (p_half_two) else $error("half duty two commons wrong");

	property p_half_dup;
		(live && ctrl.duty == LCPF_DUTY_HALF && ctrl.com_dup) |=>
			(com_en == 4'hf && com_o[3] == com_o[2] && com_o[1] == com_o[0]
			 && com_o[0] == $past(phase[0]) && com_o[2] == $past(phase[1]));
	endproperty
	a_half_dup: assert property (p_half_dup) else $error("half duty duplication wrong");

	property p_third;
		(live && ctrl.duty == LCPF_DUTY_THIRD) |=>
			(com_en == 4'h7 && !com_o[3] && com_o[2:0] == $past(phase[2:0]));
	endproperty
	a_third: assert property (p_third) else $error("third duty commons wrong");

	property p_quarter;
		(live && ctrl.duty == LCPF_DUTY_QUARTER) |=> (com_en == 4'hf && com_o == $past(phase));
	endproperty
	a_quarter: assert property (p_quarter) else $error("quarter duty commons wrong");

endmodule

`default_nettype wire

/* verilog/lcpf_pin_ctrl.sv */
// Top: LCD pin function control register, segment pin mux, common mapping
// ----------------------------------------------------------------
// Notes on behaviour
// - Group code zero: every segment pin is port
// - Static, no duplicate: only first common driven
// - Static, duplicate: all commons copy first
// - Half duty, no duplicate: first two commons
// - Half duty duplicate: all four, first pair copies first slot, second pair copies second
// - Third duty: three commons, fourth idle
// ----------------------------------------------------------------
//
// Strobed register access is this design's own decision.
`timescale 1ns/100ps
`default_nettype none

module lcpf_pin_ctrl
	import lcpf_pkg::*;
(
	input  wire logic         CLK,       // 10 MHz system clock
	input  wire logic         RST_N,     // Async reset, active low
	input  wire logic [7:0]   ADDR,      // Register address
	input  wire logic [7:0]   WDATA,     // Write data
	input  wire logic         WR,        // Write strobe
	input  wire logic         RD,        // Read strobe
	output var  logic [7:0]   RDATA,     // Read data, cycle after read
	output var  lcpf_ctrl_s   CTRL,      // Control fields to LCD timing
	input  wire logic [39:0]  SEG_WAVE,  // Segment driver waveforms
	input  wire lcpf_exp_s    EXP_SIG,   // Expansion driver signals
	input  wire logic [39:0]  PORT_DO,   // Port output data
	input  wire logic [39:0]  PORT_OE,   // Port direction, 1 drives
	output var  logic [39:0]  PORT_DI,   // Synchronised pin levels
	input  wire logic [39:0]  SEG_I,     // Segment pin input
	output var  logic [39:0]  SEG_O,     // Segment pin output
	output var  logic [39:0]  SEG_OE,    // Segment pin output enable
	input  wire logic [3:0]   COM_PHASE, // Common slot waveforms
	output var  logic [3:0]   COM_O,     // Common pin levels
	output var  logic [3:0]   COM_OE     // Common pin drive enables
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	lcpf_ctrl_s                   ctrl;
	lcpf_ctrl_s                   next_ctrl;
	logic [LCPF_DATA_W-1:0]       next_rdata;
	logic                         wr_hit;
	logic                         rd_hit;
	logic                         live;
	logic                         next_live;
	logic [LCPF_GROUPS-1:0]       grp_seg;
	logic                         exp_on;
	logic [LCPF_EXP_N-1:0]        exp_bits;
	wire  logic [39:0]            next_seg_o;
	wire  logic [39:0]            next_seg_oe;
	logic [39:0]                  pin_meta;

	// ----------------------------------------------------------------
	// Control register
	// ----------------------------------------------------------------
	always_comb begin
		wr_hit     = WR && (ADDR == LCPF_CTRL_OFF);
		rd_hit     = RD && (ADDR == LCPF_CTRL_OFF);
		next_ctrl  = ctrl;
		next_rdata = LCPF_READ_IDLE;
		next_live  = 1'b1;
		if (wr_hit) begin
			next_ctrl = lcpf_ctrl_s'(WDATA);
		end
		if (rd_hit) begin
			next_rdata = ctrl;
		end
	end

	// Read data stand for one cycle only; idle value otherwise
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			ctrl  <= lcpf_ctrl_s'(LCPF_CTRL_RESET);
			RDATA <= LCPF_READ_IDLE;
			live  <= 1'b0;
		end else begin
			ctrl  <= next_ctrl;
			RDATA <= next_rdata;
			live  <= next_live;
		end
	end

	always_comb begin
		CTRL = ctrl;
	end

	// ----------------------------------------------------------------
	// Segment group decode
	// ----------------------------------------------------------------
	// Bit 0 is the top group; codes 1, 2, 4, 6 and 8 each add the next group down
	always_comb begin
		case (ctrl.group[3:1])
			3'h0: grp_seg = ctrl.group[0] ? 5'h01 : 5'h00;
			3'h1: grp_seg = 5'h03;
			3'h2: grp_seg = 5'h07;
			3'h3: grp_seg = 5'h0f;
			default: grp_seg = 5'h1f;
		endcase
	end

	// Expansion pins stay ports while the group code is zero
	always_comb begin
		exp_on   = ctrl.exp_sel && (ctrl.group != LCPF_ALL_PORT);
		exp_bits = EXP_SIG;
	end

	// ----------------------------------------------------------------
	// Per-pin mux
	// ----------------------------------------------------------------
	genvar i;
	for (i = 0; i < LCPF_SEG_PINS; i = i + 1) begin : g_pin
		localparam int GRP = (LCPF_SEG_PINS - 1 - i) / LCPF_GROUP_W;
		if (i >= LCPF_EXP_LSB) begin : g_top
			assign next_seg_o[i]  = exp_on ? exp_bits[i - LCPF_EXP_LSB]
				: (grp_seg[GRP] ? SEG_WAVE[i] : PORT_DO[i]);
			assign next_seg_oe[i] = exp_on | grp_seg[GRP] | PORT_OE[i];
		end else begin : g_low
			assign next_seg_o[i]  = grp_seg[GRP] ? SEG_WAVE[i] : PORT_DO[i];
			assign next_seg_oe[i] = grp_seg[GRP] | PORT_OE[i];
		end
	end

	// Pin drive from flops, so a mode change never glitches the panel
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			SEG_O  <= 40'h0;
			SEG_OE <= 40'h0;
		end else begin
			SEG_O  <= next_seg_o;
			SEG_OE <= next_seg_oe;
		end
	end

	// ----------------------------------------------------------------
	// Port input synchroniser
	// ----------------------------------------------------------------
	// Pins are asynchronous; only the second stage is read
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			pin_meta <= 40'h0;
			PORT_DI  <= 40'h0;
		end else begin
			pin_meta <= SEG_I;
			PORT_DI  <= pin_meta;
		end
	end

	// ----------------------------------------------------------------
	// Common drivers
	// ----------------------------------------------------------------
	lcpf_com_map u_com (
		.clk    (CLK),
		.rst_n  (RST_N),
		.ctrl   (ctrl),
		.phase  (COM_PHASE),
		.com_o  (COM_O),
		.com_en (COM_OE)
	);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// Gated by live so the edge that releases reset is not judged
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_N);

	sequence s_write;
		live && wr_hit;
	endsequence

	sequence s_read;
		live && rd_hit;
	endsequence

	sequence s_port_cfg;
		live && (ctrl.group == LCPF_ALL_PORT);
	endsequence

	sequence s_exp_cfg;
		live && ctrl.exp_sel && (ctrl.group != LCPF_ALL_PORT);
	endsequence

	sequence s_full_cfg;
		live && ctrl.group[3] && !ctrl.exp_sel;
	endsequence

	sequence s_one_cfg;
		live && (ctrl.group == 4'h1) && !ctrl.exp_sel;
	endsequence

	property p_write_lands;
		s_write |=> (ctrl == $past(WDATA));
	endproperty
	a_write_lands: assert property (p_write_lands) else $error("control write lost");

	property p_read_data;
		s_read |=> (RDATA == $past(ctrl));
	endproperty
	a_read_data: assert property (p_read_data) else $error("read data wrong");

	property p_all_port;
		s_port_cfg |=> (SEG_OE == $past(PORT_OE) && SEG_O == $past(PORT_DO));
	endproperty
	a_all_port: assert property (p_all_port) else $error("segment pin not port");

	property p_exp_pins;
		s_exp_cfg |=> (SEG_OE[39:36] == 4'hf && SEG_O[39:36] == $past(exp_bits));
	endproperty
	a_exp_pins: assert property (p_exp_pins) else $error("expansion pins wrong");

	property p_full_seg;
		s_full_cfg |=> (SEG_OE == 40'hffffffffff && SEG_O == $past(SEG_WAVE));
	endproperty
	a_full_seg: assert property (p_full_seg) else $error("full segment mode wrong");

	property p_one_group;
		s_one_cfg |=> (SEG_OE[39:32] == 8'hff && SEG_OE[31:0] == $past(PORT_OE[31:0]));
	endproperty
	a_one_group: assert property (p_one_group) else $error("first group mode wrong");

	property p_sync;
		(live && $past(live)) |-> (PORT_DI == $past(SEG_I, 2));
	endproperty
	a_sync: assert property (p_sync) else $error("port input sync wrong");

endmodule

`default_nettype wire

/* tb/lcpf_panel.sv */
// Pin-side model: panel and outside drivers on the segment pins
`timescale 1ns/100ps
`default_nettype none
module lcpf_panel (
	input  wire logic [39:0] seg_o,  // Block pin drive
	input  wire logic [39:0] seg_oe, // Block pin enable
	input  wire logic [39:0] ext,    // Outside driver level
	output var  logic [39:0] pin     // Resolved pin level
);
	// Released pins take the outside level, never a stale block value
	always_comb pin = (seg_o & seg_oe) | (ext & ~seg_oe);
endmodule
`default_nettype wire

/* tb/lcpf_pin_ctrl_tb.sv */
// Testbench for the LCD pin function control block
`timescale 1ns/100ps
`default_nettype none
module lcpf_pin_ctrl_tb
	import lcpf_pkg::*;
;
	logic              CLK = 1'b0;
	logic              RST_N = 1'b0;
	logic [7:0]        ADDR = 8'h00;
	logic [7:0]        WDATA = 8'h00;
	logic              WR = 1'b0;
	logic              RD = 1'b0;
	logic [7:0]        RDATA;
	lcpf_ctrl_s        CTRL;
	logic [39:0]       SEG_WAVE = 40'h5a3c96e1f0;
	lcpf_exp_s         EXP_SIG = 4'h9;
	logic [39:0]       PORT_DO = 40'ha5c3691e0f;
	logic [39:0]       PORT_OE = 40'h0;
	logic [39:0]       EXT = 40'hc3a50f691e;
	logic [39:0]       PORT_DI, SEG_I, SEG_O, SEG_OE;
	logic [3:0]        COM_PHASE = 4'h5;
	logic [3:0]        COM_O, COM_OE;
	int                num_errors = 0;
	int                checks_done = 0;
	int                cyc = 0;

	lcpf_pin_ctrl uut (.CLK(CLK), .RST_N(RST_N),
		.ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .CTRL(CTRL),
		.SEG_WAVE(SEG_WAVE), .EXP_SIG(EXP_SIG), .PORT_DO(PORT_DO), .PORT_OE(PORT_OE),
		.PORT_DI(PORT_DI), .SEG_I(SEG_I), .SEG_O(SEG_O), .SEG_OE(SEG_OE),
		.COM_PHASE(COM_PHASE), .COM_O(COM_O), .COM_OE(COM_OE));
	lcpf_panel panel (.seg_o(SEG_O), .seg_oe(SEG_OE), .ext(EXT), .pin(SEG_I));

	always #50 CLK = ~CLK;
	// Hang guard, far above the hundred or so cycles the tests need
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 2000) begin
			num_errors++;
			test_done;
		end
	end

	// ----------------------------------------------------------------
	// Access and compare tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLK);
		WR <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLK);
		RD <= 1'b0;
		@(negedge CLK);
		d = RDATA;
	endtask
	task automatic seg_case(input logic [3:0] g, input logic x);
		int n;
		logic [39:0] m, e, oe;
		n = (g == 0) ? 0 : (g == 1) ? 1 : (g < 4) ? 2 : (g < 6) ? 3 : (g < 8) ? 4 : 5;
		m = ~40'((41'h1 << (40 - 8 * n)) - 41'h1);
		e = (SEG_WAVE & m) | (PORT_DO & ~m);
		if (x && n > 0)
			e[39:36] = EXP_SIG;
		oe = m | (PORT_OE & ~m);
		wr(LCPF_CTRL_OFF, {3'h0, x, g});
		// Pin flop plus two sync stages before port input settles
		repeat (4) @(negedge CLK);
		chk("seg_oe", SEG_OE, oe);
		chk("seg_o", SEG_O & oe, e & oe);
		chk("port_di", PORT_DI & ~m, ((PORT_DO & PORT_OE) | (EXT & ~PORT_OE)) & ~m);
	endtask
	task automatic com_case(input logic [2:0] c, input logic [3:0] oe, input logic [3:0] o);
		wr(LCPF_CTRL_OFF, {c, 5'h00});
		repeat (3) @(negedge CLK);
		chk("com_oe", {36'h0, COM_OE}, {36'h0, oe});
		chk("com_o", {36'h0, COM_O & oe}, {36'h0, o});
	endtask
	task automatic test_done;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [7:0] d;
		repeat (12) @(posedge CLK);
		RST_N <= 1'b1;
		PORT_OE <= 40'h00ff00ff00;
		rd(LCPF_CTRL_OFF, d);
		chk("reset", {32'h0, d}, {32'h0, LCPF_CTRL_RESET});
		wr(LCPF_CTRL_OFF, 8'ha5);
		rd(LCPF_CTRL_OFF, d);
		chk("readback", {32'h0, d}, 40'ha5);
		chk("ctrl", {32'h0, CTRL}, 40'ha5);
		rd(8'hc1, d);
		chk("unmapped", {32'h0, d}, {32'h0, LCPF_READ_IDLE});
		seg_case(4'h0, 1'b1);
		seg_case(4'h1, 1'b0);
		seg_case(4'h3, 1'b0);
		seg_case(4'h4, 1'b0);
		seg_case(4'h7, 1'b0);
		seg_case(4'h8, 1'b0);
		seg_case(4'h8, 1'b1);
		com_case(3'h0, 4'h1, 4'h1);
		com_case(3'h1, 4'hf, 4'hf);
		com_case(3'h2, 4'h3, 4'h1);
		com_case(3'h3, 4'hf, 4'h3);
		com_case(3'h4, 4'h7, 4'h5);
		com_case(3'h5, 4'h7, 4'h5);
		com_case(3'h6, 4'hf, 4'h5);
		com_case(3'h7, 4'hf, 4'h5);
		test_done;
	end
endmodule
`default_nettype wire
